// ===== src/bceic_defines.svh
`ifndef BCEIC_DEFINES_SVH
`define BCEIC_DEFINES_SVH
`define BCEIC_CMD_W 16
`define BCEIC_BIT_PAR_RESP 6
`define BCEIC_BIT_WAIT_CYC 7
`define BCEIC_BIT_SERR_EN 8
`define BCEIC_BIT_B2B 9
`define BCEIC_BIT_INT_DIS 10
`define BCEIC_CMD_RESET 16'h0000
`define BCEIC_IRQ_W 4
`define BCEIC_SYNC_STAGES 2
`endif

// ===== src/bceic_pkg.sv
package bceic_pkg;
  typedef struct packed {
    logic par_resp_en;
    logic system_error_report_en;
    logic int_dis;
  } bceic_ctrl_t;
  typedef struct packed {
    logic poisoned_tlp;
    logic parity_err;
    logic fatal;
    logic nonfatal;
  } bceic_evt_t;
  typedef enum logic [1:0] {
    BCEIC_SERR_IDLE,
    BCEIC_SERR_ACTIVE
  } bceic_serr_st_t;
endpackage

// ===== src/bceic_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "bceic_defines.svh"
module bceic_sync #(
  parameter int WIDTH = 1
) (
  // clocking
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;
  if (WIDTH < 1) begin : g_bad_width
    $error("bceic_sync width must be at least 1");
  end
  always_comb begin
    nxt_stage1 = stage1_ff;
    nxt_stage2 = stage2_ff;
    if (clk_en) begin
      nxt_stage1 = async_in;
      nxt_stage2 = stage1_ff;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end
  assign sync_out = stage2_ff;
endmodule
`default_nettype wire

// ===== src/bceic_top.sv
// Function
// - parity response on: flag poisoned/parity events
// - parity response off: events ignored, no flag
// - wait cycle bit reads zero, ignores writes
// - serr enable gates upstream error messages forward
// - reverse mode: serr output only when enabled
// - back-to-back enable bit reads zero always
// - interrupt disable writable only in reverse mode
// - reverse mode: disable holds legacy interrupts off
`timescale 1ns/1ps
`default_nettype none
`include "bceic_defines.svh"
module bceic_top
  import bceic_pkg::*;
#(
  parameter int CMD_W = `BCEIC_CMD_W
) (
  // clocking
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // mode: 1 = reverse bridge, 0 = forward bridge (strap pin)
  input wire logic reverse_mode,
  // command register access
  input wire logic cmd_wr,
  input wire logic [CMD_W-1:0] cmd_wdata,
  output logic [CMD_W-1:0] cmd_rdata,
  // error events from the datapath
  input wire bceic_evt_t err_evt,
  // status flag and its clear
  input wire logic mdpe_clr,
  output logic master_data_parity_err,
  // upstream error message requests
  output logic err_msg_fatal,
  output logic err_msg_nonfatal,
  // primary system error pin
  output logic system_error_out_n,
  // legacy interrupts, active-low requests in, pins out
  input wire logic [`BCEIC_IRQ_W-1:0] irq_req_n,
  output logic legacy_irq_a_n,
  output logic legacy_irq_b_n,
  output logic legacy_irq_c_n,
  output logic legacy_irq_d_n
);
  // the highest control bit must fit inside the command word
  if (CMD_W <= `BCEIC_BIT_INT_DIS) begin : g_bad_cmd_w
    $error("command width too small");
  end

  logic [`BCEIC_IRQ_W-1:0] irq_req_n_s;
  logic reverse_s;
  bceic_ctrl_t ctrl_ff;
  bceic_ctrl_t nxt_ctrl;
  logic mdpe_ff;
  logic nxt_mdpe;
  logic fatal_ff;
  logic nxt_fatal;
  logic nonfatal_ff;
  logic nxt_nonfatal;
  logic serr_n_ff;
  logic nxt_serr_n;
  logic [`BCEIC_IRQ_W-1:0] irq_n_ff;
  logic [`BCEIC_IRQ_W-1:0] nxt_irq_n;
  logic [CMD_W-1:0] rdata_ff;
  logic [CMD_W-1:0] nxt_rdata;
  bceic_serr_st_t serr_st_ff;
  bceic_serr_st_t nxt_serr_st;

  // interrupt requests and the mode strap come from pins
  bceic_sync #(
    .WIDTH(`BCEIC_IRQ_W + 1)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .async_in({reverse_mode, irq_req_n}),
    .sync_out({reverse_s, irq_req_n_s})
  );

  function automatic logic [CMD_W-1:0] pack_cmd(input bceic_ctrl_t c);
    logic [CMD_W-1:0] v;
    v = '0;
    v[`BCEIC_BIT_PAR_RESP] = c.par_resp_en;
    v[`BCEIC_BIT_SERR_EN] = c.system_error_report_en;
    v[`BCEIC_BIT_INT_DIS] = c.int_dis;
    // wait cycle and back-to-back positions stay zero
    v[`BCEIC_BIT_WAIT_CYC] = 1'b0;
    v[`BCEIC_BIT_B2B] = 1'b0;
    return v;
  endfunction

  // command bits
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (clk_en && cmd_wr) begin
      nxt_ctrl.par_resp_en = cmd_wdata[`BCEIC_BIT_PAR_RESP];
      nxt_ctrl.system_error_report_en = cmd_wdata[`BCEIC_BIT_SERR_EN];
      // forward mode keeps the disable bit frozen
      if (reverse_s) begin
        nxt_ctrl.int_dis = cmd_wdata[`BCEIC_BIT_INT_DIS];
      end
    end
    nxt_rdata = rdata_ff;
    if (clk_en) begin
      nxt_rdata = pack_cmd(nxt_ctrl);
    end
  end

  // parity status flag: a new event beats a simultaneous clear
  always_comb begin
    nxt_mdpe = mdpe_ff;
    if (clk_en) begin
      if (mdpe_clr) begin
        nxt_mdpe = 1'b0;
      end
      if (ctrl_ff.par_resp_en && (err_evt.poisoned_tlp || err_evt.parity_err)) begin
        nxt_mdpe = 1'b1;
      end
      // with response off, events fall through untouched
    end
  end

  // error reporting: messages upstream in forward, pin in reverse
  always_comb begin
    nxt_fatal = 1'b0;
    nxt_nonfatal = 1'b0;
    nxt_serr_st = serr_st_ff;
    nxt_serr_n = serr_n_ff;
    if (clk_en) begin
      if (!reverse_s && ctrl_ff.system_error_report_en) begin
        nxt_fatal = err_evt.fatal;
        nxt_nonfatal = err_evt.nonfatal;
      end
      case (serr_st_ff)
        BCEIC_SERR_IDLE: begin
          if (reverse_s && ctrl_ff.system_error_report_en && (err_evt.fatal || err_evt.nonfatal)) begin
            nxt_serr_st = BCEIC_SERR_ACTIVE;
          end
        end
        BCEIC_SERR_ACTIVE: begin
          // pin goes low one cycle per event cycle; back-to-back events hold it low
          nxt_serr_st = BCEIC_SERR_IDLE;
          if (reverse_s && ctrl_ff.system_error_report_en && (err_evt.fatal || err_evt.nonfatal)) begin
            nxt_serr_st = BCEIC_SERR_ACTIVE;
          end
        end
        default: begin
          nxt_serr_st = BCEIC_SERR_IDLE;
        end
      endcase
      nxt_serr_n = (nxt_serr_st == BCEIC_SERR_ACTIVE) ? 1'b0 : 1'b1;
    end else begin
      nxt_fatal = fatal_ff;
      nxt_nonfatal = nonfatal_ff;
    end
  end

  // legacy interrupt gating
  always_comb begin
    nxt_irq_n = irq_n_ff;
    if (clk_en) begin
      for (int i = 0; i < `BCEIC_IRQ_W; i++) begin
        // forward mode drives no legacy pins on this side
        if (!reverse_s || ctrl_ff.int_dis) begin
          nxt_irq_n[i] = 1'b1;
        end else begin
          nxt_irq_n[i] = irq_req_n_s[i];
        end
      end
    end
  end

  // control bits and their readback move together, so readback never lags the gates
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= '0;
      rdata_ff <= CMD_W'(`BCEIC_CMD_RESET);
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  // sticky parity status
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mdpe_ff <= 1'b0;
    end else begin
      mdpe_ff <= nxt_mdpe;
    end
  end

  // error reporting: pin idles high so a reset never looks like an error
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fatal_ff <= 1'b0;
      nonfatal_ff <= 1'b0;
      serr_st_ff <= BCEIC_SERR_IDLE;
      serr_n_ff <= 1'b1;
    end else begin
      fatal_ff <= nxt_fatal;
      nonfatal_ff <= nxt_nonfatal;
      serr_st_ff <= nxt_serr_st;
      serr_n_ff <= nxt_serr_n;
    end
  end

  // legacy pins come out of reset deasserted
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_ff <= '1;
    end else begin
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign cmd_rdata = rdata_ff;
  assign master_data_parity_err = mdpe_ff;
  assign err_msg_fatal = fatal_ff;
  assign err_msg_nonfatal = nonfatal_ff;
  assign system_error_out_n = serr_n_ff;
  assign legacy_irq_a_n = irq_n_ff[0];
  assign legacy_irq_b_n = irq_n_ff[1];
  assign legacy_irq_c_n = irq_n_ff[2];
  assign legacy_irq_d_n = irq_n_ff[3];
endmodule
`default_nettype wire

// ===== bench/bceic_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bceic_top_monitor
  import bceic_pkg::*;
#(
  parameter int CMD_W = 16
) (
  // clocking
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic reverse_mode,
  // command and events
  input wire logic cmd_wr,
  input wire logic [CMD_W-1:0] cmd_rdata,
  input wire bceic_evt_t err_evt,
  // results
  input wire logic master_data_parity_err,
  input wire logic err_msg_fatal,
  input wire logic system_error_out_n,
  input wire logic legacy_irq_a_n,
  input wire logic legacy_irq_b_n,
  input wire logic legacy_irq_c_n,
  input wire logic legacy_irq_d_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // three enabled samples cover the two-stage mode synchroniser, which freezes with clk_en
  sequence fwd_s; (!reverse_mode && clk_en) [*3]; endsequence
  sequence rev_s; (reverse_mode && clk_en) [*3]; endsequence
  wait_ro_a: assert property (cmd_rdata[7] == 1'b0) else $error("wait bit set");
  b2b_ro_a: assert property (cmd_rdata[9] == 1'b0) else $error("b2b bit set");
  par_set_a: assert property (clk_en && err_evt.parity_err && cmd_rdata[6] |=> master_data_parity_err)
    else $error("flag not set");
  par_off_a: assert property (!cmd_rdata[6] && !master_data_parity_err |=> !master_data_parity_err)
    else $error("flag set while off");
  msg_gate_a: assert property (err_msg_fatal |-> $past(cmd_rdata[8])) else $error("msg not enabled");
  msg_fwd_a: assert property (fwd_s ##0 (clk_en && err_evt.fatal && cmd_rdata[8]) |=> err_msg_fatal)
    else $error("msg missing");
  serr_rev_a: assert property (rev_s ##0 (clk_en && err_evt.fatal && cmd_rdata[8]) |=> !system_error_out_n)
    else $error("serr missing");
  // pins are launched from the bit as it stood one enabled edge earlier
  irq_off_a: assert property ($past(clk_en) && $past(cmd_rdata[10]) |->
    {legacy_irq_a_n, legacy_irq_b_n, legacy_irq_c_n, legacy_irq_d_n} == 4'hf) else $error("irq not held");
  int_ro_a: assert property (fwd_s ##0 (cmd_wr) |=> $stable(cmd_rdata[10])) else $error("int dis written");
endmodule
bind bceic_top bceic_top_monitor #(.CMD_W(CMD_W)) mon (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
  .reverse_mode(reverse_mode), .cmd_wr(cmd_wr), .cmd_rdata(cmd_rdata), .err_evt(err_evt),
  .master_data_parity_err(master_data_parity_err), .err_msg_fatal(err_msg_fatal),
  .system_error_out_n(system_error_out_n), .legacy_irq_a_n(legacy_irq_a_n), .legacy_irq_b_n(legacy_irq_b_n),
  .legacy_irq_c_n(legacy_irq_c_n), .legacy_irq_d_n(legacy_irq_d_n));
`default_nettype wire

// ===== bench/bceic_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bceic_host_model
  import bceic_pkg::*;
(
  // clocking
  input wire logic core_clk,
  // requests toward the block
  output logic cmd_wr,
  output logic [15:0] cmd_wdata,
  output bceic_evt_t err_evt,
  output logic mdpe_clr
);
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
    err_evt = '0;
    mdpe_clr = 1'b0;
  end
  task automatic wr(input logic [15:0] d);
    @(negedge core_clk);
    cmd_wr = 1'b1;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    // stale data is inverted so a late capture cannot pass by luck
    cmd_wdata = ~d;
  endtask
  task automatic evt(input logic [3:0] e, input logic clr);
    @(negedge core_clk);
    err_evt = e;
    mdpe_clr = clr;
    @(negedge core_clk);
    err_evt = '0;
    mdpe_clr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/bceic_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bceic_top_bench;
  import bceic_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reverse_mode = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] irq_req_n = 4'hf;
  logic cmd_wr, mdpe_clr, flag, fat, nfat, serr_n;
  logic [15:0] cmd_wdata, rd;
  logic [3:0] pins;
  bceic_evt_t err_evt;
  int error_cnt = 0;
  int num_checks = 0;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  always #12.5 core_clk = ~core_clk;
  bceic_host_model host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .err_evt(err_evt),
    .mdpe_clr(mdpe_clr));
  bceic_top bceic_top_inst (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .reverse_mode(reverse_mode),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(rd), .err_evt(err_evt), .mdpe_clr(mdpe_clr),
    .master_data_parity_err(flag), .err_msg_fatal(fat), .err_msg_nonfatal(nfat), .system_error_out_n(serr_n),
    .irq_req_n(irq_req_n), .legacy_irq_a_n(pins[0]), .legacy_irq_b_n(pins[1]), .legacy_irq_c_n(pins[2]),
    .legacy_irq_d_n(pins[3]));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #10000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    `CHK({rd, flag, serr_n, pins}, {16'h0000, 1'b0, 1'b1, 4'hf})
    // the mode strap needs two edges through its synchroniser before the first write
    repeat (2) @(negedge core_clk);
    host.wr(16'hffff);
    `CHK(rd, 16'h0540)
    irq_req_n = 4'h0;
    repeat (4) @(negedge core_clk);
    `CHK(pins, 4'hf)
    host.evt(4'h2, 1'b0);
    `CHK({serr_n, fat}, 2'b00)
    host.wr(16'h0040);
    @(negedge core_clk);
    `CHK(pins, 4'h0)
    irq_req_n = 4'h5;
    repeat (3) @(negedge core_clk);
    `CHK(pins, 4'h5)
    host.evt(4'h6, 1'b0);
    `CHK({flag, serr_n}, 2'b11)
    host.evt(4'h0, 1'b1);
    host.evt(4'h8, 1'b0);
    `CHK(flag, 1'b1)
    host.evt(4'h0, 1'b1);
    host.wr(16'h0400);
    host.evt(4'hc, 1'b0);
    `CHK({rd, flag}, {16'h0400, 1'b0})
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    host.wr(16'h0140);
    `CHK(rd, 16'h0400)
    clk_en = 1'b1;
    host.wr(16'h0440);
    // event and clear in one cycle: the event wins
    host.evt(4'h4, 1'b1);
    `CHK({rd, flag}, {16'h0440, 1'b1})
    $display("reverse mode test done");
    reverse_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    host.wr(16'h0100);
    `CHK(rd, 16'h0500)
    host.evt(4'h2, 1'b0);
    `CHK({fat, nfat, serr_n}, 3'b101)
    host.evt(4'h1, 1'b0);
    `CHK({fat, nfat}, 2'b01)
    host.wr(16'h0000);
    host.evt(4'h3, 1'b0);
    `CHK({rd, fat, nfat}, {16'h0400, 2'b00})
    $display("forward mode test done");
    rstn = 1'b0;
    @(negedge core_clk);
    `CHK({rd, flag, fat, nfat, serr_n, pins}, {16'h0000, 3'b000, 1'b1, 4'hf})
    rstn = 1'b1;
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire
